// file: common/adc_seq_pkg.sv
// Shared types and constants of the conversion sequencer
package adc_seq_pkg;

  // ==========================================================
  // Widths
  localparam int CHAN_W   = 4;
  localparam int RESULT_W = 10;
  localparam int HALF_W   = 6;
  localparam int DIV_W    = 3;
  localparam int PCNT_W   = 7;

  // ==========================================================
  // Timing in converter clock half cycles, counted from start
  localparam logic [HALF_W-1:0] FIRST_SH_HALF    = 6'h1b;  // 13.5
  localparam logic [HALF_W-1:0] FIRST_TOTAL_HALF = 6'h32;  // 25
  localparam logic [HALF_W-1:0] NORM_SH_HALF     = 6'h03;  // 1.5
  localparam logic [HALF_W-1:0] NORM_TOTAL_HALF  = 6'h1a;  // 13
  localparam logic [HALF_W-1:0] AUTO_SH_HALF     = 6'h04;  // 2
  localparam logic [HALF_W-1:0] AUTO_TOTAL_HALF  = 6'h1b;  // 13.5
  localparam logic [HALF_W-1:0] FREE_SH_HALF     = 6'h05;  // 2.5
  localparam logic [HALF_W-1:0] FREE_TOTAL_HALF  = 6'h1c;  // 14
  // Selection unlocks for the last converter clock cycle
  localparam logic [HALF_W-1:0] LAST_CYCLE_HALF  = 6'h02;

  // Trigger synchroniser depth in CPU clocks
  localparam int TRIG_SYNC_STAGES = 3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_EDGE,
    ST_CONVERT
  } conv_state_t;

  typedef enum logic [1:0] {
    PROF_FIRST,
    PROF_NORMAL,
    PROF_AUTO,
    PROF_FREE
  } profile_t;

  typedef struct packed {
    logic              reference_select_bit;
    logic [CHAN_W-1:0] input_channel_field;
  } selection_t;

  typedef struct packed {
    selection_t          sel;
    logic [RESULT_W-1:0] value;
  } result_word_t;

endpackage

// file: design/adc_prescaler.sv
// Converter clock prescaler producing rising and falling edge strobes
`timescale 1ns/1ps
`default_nettype none

module adc_prescaler #(
  parameter int CNT_W = adc_seq_pkg::PCNT_W
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_converter_on,
  input  wire logic                         i_sync_reset,
  input  wire logic [adc_seq_pkg::DIV_W-1:0] i_clock_divider_select,
  output logic                              o_rise,
  output logic                              o_fall
);

  // ==========================================================
  // Ratio 2 for codes 0 and 1, else two to the code
  function automatic logic [CNT_W:0] ratio(input logic [adc_seq_pkg::DIV_W-1:0] sel);
    logic [CNT_W:0] r;
    r = (CNT_W+1)'(1) << sel;
    if (sel == 3'h0) begin
      r = (CNT_W+1)'(2);
    end
    return r;
  endfunction

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } state_t;

  state_t         s;
  state_t         next_s;
  logic [CNT_W:0] div;

  // ==========================================================
  // Edges are decoded from the count, so a reset costs no extra cycle
  always_comb begin
    div    = ratio(i_clock_divider_select);
    o_rise = i_converter_on && ({1'b0, s.count} == div - (CNT_W+1)'(1));
    o_fall = i_converter_on && ({1'b0, s.count} == (div >> 1) - (CNT_W+1)'(1));
    next_s = s;
    if (!i_converter_on || i_sync_reset) begin
      next_s.count = '0;
    end else if ({1'b0, s.count} >= div - (CNT_W+1)'(1)) begin
      // Also catches a count left above a newly chosen smaller ratio
      next_s.count = '0;
    end else begin
      next_s.count = s.count + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// file: design/result_buffer.sv
// Small valid/ready buffer for finished conversion results
`timescale 1ns/1ps
`default_nettype none

module result_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [PTR_W:0]              fill;
  } state_t;

  state_t s;
  state_t next_s;
  logic   push;
  logic   pop;

  // ==========================================================
  // Pointer wrap kept explicit so DEPTH need not be a power of two
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  always_comb begin
    o_in_ready  = (s.fill != (PTR_W+1)'(DEPTH));
    o_out_valid = (s.fill != '0);
    o_out_data  = s.mem[s.rd];
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    next_s      = s;
    if (push) begin
      next_s.mem[s.wr] = i_in_data;
      next_s.wr        = bump(s.wr);
    end
    if (pop) begin
      next_s.rd = bump(s.rd);
    end
    if (push && !pop) begin
      next_s.fill = s.fill + (PTR_W+1)'(1);
    end else if (pop && !push) begin
      next_s.fill = s.fill - (PTR_W+1)'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// file: design/adc_conversion_sequencer.sv
// Conversion sequencer of a successive-approximation converter
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Prescaler counts while converter is on, held reset while it is off.
// - Converter clock is the CPU clock divided by the selected ratio.
// - A written start flag begins conversion at next converter clock rise.
// - Normal conversion lasts 13 cycles, sample-and-hold at 1.5.
// - First conversion after switch-on lasts 25 cycles, sample at 13.5.
// - Completion stores result, sets done flag, clears start flag in single mode.
// - Trigger resets prescaler; sample at 2 cycles, conversion 13.5 cycles.
// - Trigger synchronisation adds three CPU clocks before auto start.
// - Free running restarts on completion with start flag kept high.
// - Selection follows temporary register until start, then is locked.
// - Selection copying resumes in the last converter cycle of a conversion.
// - Free running change after completion applies from the conversion after next.
// - Halting in quiet sleep, idle, single mode, interrupt on starts conversion.
// - Conversion started in sleep still raises its interrupt after early wake.
// - Other sleep modes do not switch the converter off.
// - Start flag reads one throughout any conversion in progress.
// - Trigger edges during a conversion are ignored.
// - Low byte read blocks result update until high byte read; flag still set.
module adc_conversion_sequencer #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  // Control bits
  input  wire logic                             i_converter_on,
  input  wire logic                             i_start_write,
  input  wire logic                             i_auto_trigger_on,
  input  wire logic                             i_free_running,
  input  wire logic [adc_seq_pkg::DIV_W-1:0]    i_clock_divider_select,
  input  wire logic                             i_done_clear,
  input  wire logic                             i_done_int_enable,
  input  wire logic                             i_trigger,
  input  wire logic                             i_sleep_halt,
  // Temporary selection write
  input  wire logic                             i_select_write,
  input  wire logic [adc_seq_pkg::CHAN_W-1:0]   i_input_channel_field,
  input  wire logic                             i_reference_select_bit,
  // Data register reads
  input  wire logic                             i_read_low,
  input  wire logic                             i_read_high,
  // Analog front end
  input  wire logic [adc_seq_pkg::RESULT_W-1:0] i_sar_value,
  output logic                                  o_sample_hold,
  output logic                                  o_converting,
  output logic      [adc_seq_pkg::CHAN_W-1:0]   o_active_channel,
  output logic                                  o_active_reference,
  // Status
  output logic                                  o_conversion_start_flag,
  output logic                                  o_conversion_done_flag,
  output logic                                  o_irq_request,
  output logic      [7:0]                       o_result_low_byte,
  output logic      [7:0]                       o_result_high_byte,
  // Result stream
  output logic                                  o_result_valid,
  input  wire logic                             i_result_ready,
  output adc_seq_pkg::result_word_t             o_result_data
);

  // ==========================================================
  // Profile lookup

  function automatic logic [adc_seq_pkg::HALF_W-1:0] sh_half(
    input adc_seq_pkg::profile_t p
  );
    logic [adc_seq_pkg::HALF_W-1:0] h;
    case (p)
      adc_seq_pkg::PROF_FIRST: h = adc_seq_pkg::FIRST_SH_HALF;
      adc_seq_pkg::PROF_AUTO:  h = adc_seq_pkg::AUTO_SH_HALF;
      adc_seq_pkg::PROF_FREE:  h = adc_seq_pkg::FREE_SH_HALF;
      default:                 h = adc_seq_pkg::NORM_SH_HALF;
    endcase
    return h;
  endfunction

  function automatic logic [adc_seq_pkg::HALF_W-1:0] total_half(
    input adc_seq_pkg::profile_t p
  );
    logic [adc_seq_pkg::HALF_W-1:0] h;
    case (p)
      adc_seq_pkg::PROF_FIRST: h = adc_seq_pkg::FIRST_TOTAL_HALF;
      adc_seq_pkg::PROF_AUTO:  h = adc_seq_pkg::AUTO_TOTAL_HALF;
      adc_seq_pkg::PROF_FREE:  h = adc_seq_pkg::FREE_TOTAL_HALF;
      default:                 h = adc_seq_pkg::NORM_TOTAL_HALF;
    endcase
    return h;
  endfunction

  // ==========================================================
  // State

  typedef struct packed {
    adc_seq_pkg::conv_state_t                   st;
    adc_seq_pkg::profile_t                      prof;
    logic [adc_seq_pkg::HALF_W-1:0]             half;
    logic                                       first;
    adc_seq_pkg::selection_t                    temp;
    adc_seq_pkg::selection_t                    act;
    adc_seq_pkg::selection_t                    conv_sel;
    logic                                       sel_lock;
    logic                                       start_flag;
    logic                                       done_flag;
    logic                                       res_lock;
    logic [adc_seq_pkg::RESULT_W-1:0]           result;
    logic [adc_seq_pkg::TRIG_SYNC_STAGES:0]     trig_sync;
    logic                                       halt_d;
    logic                                       sample;
  } state_t;

  state_t                         s;
  state_t                         next_s;
  logic                           rise;
  logic                           fall;
  logic                           tick;
  logic                           trig_edge;
  logic                           halt_edge;
  logic                           sleep_start;
  logic                           presc_reset;
  logic                           complete;
  logic                           buf_ready;
  logic [adc_seq_pkg::HALF_W-1:0] h_next;
  adc_seq_pkg::result_word_t      buf_in;

  // ==========================================================
  // Prescaler and result buffer

  adc_prescaler #(
    .CNT_W (adc_seq_pkg::PCNT_W)
  ) u_prescaler (
    .i_clk                  (i_clk),
    .i_rst_n                (i_rst_n),
    .i_converter_on         (i_converter_on),
    .i_sync_reset           (presc_reset),
    .i_clock_divider_select (i_clock_divider_select),
    .o_rise                 (rise),
    .o_fall                 (fall)
  );

  // A stalled reader holds the sequencer at its final half cycle
  result_buffer #(
    .WIDTH ($bits(adc_seq_pkg::result_word_t)),
    .DEPTH (BUF_DEPTH)
  ) u_result_buffer (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (complete),
    .o_in_ready  (buf_ready),
    .i_in_data   (buf_in),
    .o_out_valid (o_result_valid),
    .i_out_ready (i_result_ready),
    .o_out_data  (o_result_data)
  );

  // ==========================================================
  // Next state

  always_comb begin
    next_s      = s;
    next_s.sample = 1'b0;
    complete    = 1'b0;
    presc_reset = 1'b0;
    tick        = rise || fall;
    h_next      = s.half + adc_seq_pkg::HALF_W'(1);
    buf_in      = '{sel: s.conv_sel, value: i_sar_value};

    // Only the synchroniser's later stages feed the edge detector
    next_s.trig_sync = {s.trig_sync[adc_seq_pkg::TRIG_SYNC_STAGES-1:0], i_trigger};
    trig_edge = s.trig_sync[adc_seq_pkg::TRIG_SYNC_STAGES-1]
              && !s.trig_sync[adc_seq_pkg::TRIG_SYNC_STAGES];
    next_s.halt_d = i_sleep_halt;
    halt_edge     = i_sleep_halt && !s.halt_d;
    // Deeper sleep modes leave the converter running as software left it
    sleep_start = halt_edge && i_converter_on && !i_auto_trigger_on
               && i_done_int_enable && (s.st == adc_seq_pkg::ST_IDLE)
               && !s.start_flag;

    if (i_select_write) begin
      next_s.temp = '{reference_select_bit: i_reference_select_bit,
                      input_channel_field:  i_input_channel_field};
    end
    if (!s.sel_lock) begin
      next_s.act = s.temp;
    end

    if (i_read_low) begin
      next_s.res_lock = 1'b1;
    end
    if (i_read_high) begin
      next_s.res_lock = 1'b0;
    end
    if (i_done_clear) begin
      next_s.done_flag = 1'b0;
    end

    case (s.st)
      adc_seq_pkg::ST_IDLE: begin
        if (i_converter_on && (i_start_write || sleep_start)) begin
          next_s.st         = adc_seq_pkg::ST_WAIT_EDGE;
          next_s.start_flag = 1'b1;
        end else if (i_converter_on && i_auto_trigger_on && !i_free_running
                     && trig_edge) begin
          presc_reset       = 1'b1;
          next_s.st         = adc_seq_pkg::ST_CONVERT;
          next_s.prof       = s.first ? adc_seq_pkg::PROF_FIRST
                                      : adc_seq_pkg::PROF_AUTO;
          next_s.half       = '0;
          next_s.first      = 1'b0;
          next_s.sel_lock   = 1'b1;
          next_s.conv_sel   = s.act;
          next_s.start_flag = 1'b1;
        end
      end
      adc_seq_pkg::ST_WAIT_EDGE: begin
        if (rise) begin
          next_s.st       = adc_seq_pkg::ST_CONVERT;
          next_s.prof     = s.first ? adc_seq_pkg::PROF_FIRST
                                    : adc_seq_pkg::PROF_NORMAL;
          next_s.half     = '0;
          next_s.first    = 1'b0;
          next_s.sel_lock = 1'b1;
          next_s.conv_sel = s.act;
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (s.half == total_half(s.prof)) begin
          complete = buf_ready;
        end else if (tick) begin
          next_s.half = h_next;
          if (h_next == sh_half(s.prof)) begin
            next_s.sample = 1'b1;
          end
          if (h_next == total_half(s.prof) - adc_seq_pkg::LAST_CYCLE_HALF) begin
            next_s.sel_lock = 1'b0;
          end
        end
        if (complete) begin
          next_s.done_flag = 1'b1;
          if (!s.res_lock) begin
            next_s.result = i_sar_value;
          end
          if (i_auto_trigger_on && i_free_running) begin
            // The restart locks what was copied in the last cycle
            next_s.st       = adc_seq_pkg::ST_CONVERT;
            next_s.prof     = adc_seq_pkg::PROF_FREE;
            next_s.half     = '0;
            next_s.sel_lock = 1'b1;
            next_s.conv_sel = s.act;
          end else if (i_start_write) begin
            next_s.st = adc_seq_pkg::ST_WAIT_EDGE;
          end else begin
            next_s.st         = adc_seq_pkg::ST_IDLE;
            next_s.start_flag = 1'b0;
          end
        end
      end
      default: begin
        next_s.st = adc_seq_pkg::ST_IDLE;
      end
    endcase

    // Turning off abandons any conversion and rearms the long first one
    if (!i_converter_on) begin
      next_s.st         = adc_seq_pkg::ST_IDLE;
      next_s.first      = 1'b1;
      next_s.sel_lock   = 1'b0;
      next_s.start_flag = 1'b0;
      next_s.half       = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs

  always_comb begin
    o_sample_hold           = s.sample;
    o_converting            = (s.st == adc_seq_pkg::ST_CONVERT);
    o_active_channel        = s.act.input_channel_field;
    o_active_reference      = s.act.reference_select_bit;
    o_conversion_start_flag = s.start_flag;
    o_conversion_done_flag  = s.done_flag;
    o_irq_request           = s.done_flag && i_done_int_enable;
    o_result_low_byte       = s.result[7:0];
    o_result_high_byte      = {6'h00, s.result[9:8]};
  end

endmodule

`default_nettype wire

// file: verif/adc_conversion_sequencer_sva.sv
// Port checks of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module adc_seq_checker (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_converter_on,
  input wire logic       i_start_write,
  input wire logic       i_auto_trigger_on,
  input wire logic       i_free_running,
  input wire logic [2:0] i_clock_divider_select,
  input wire logic       i_done_int_enable,
  input wire logic       o_sample_hold,
  input wire logic       o_converting,
  input wire logic [3:0] o_active_channel,
  input wire logic       o_active_reference,
  input wire logic       o_conversion_start_flag,
  input wire logic       o_conversion_done_flag,
  input wire logic       o_irq_request,
  input wire logic       o_result_valid
);
  // ====
  // Helper logic
  logic [11:0] ratio;
  logic [11:0] conv_len;
  assign ratio = (i_clock_divider_select == 3'h0) ? 12'h002 : 12'h001 << i_clock_divider_select;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      conv_len <= 12'h000;
    end else begin
      conv_len <= o_converting ? conv_len + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence restart_s;
    o_conversion_start_flag ##[0:3] o_converting;
  endsequence
  sequence single_end_s;
    $fell(o_converting) && !i_auto_trigger_on && i_converter_on;
  endsequence

  // ====
  // Assertions
  busy_flag_a: assert property (o_converting |-> o_conversion_start_flag)
    else $error("start flag low");
  single_clear_a: assert property ($rose(o_conversion_done_flag) && !i_auto_trigger_on
    && !$past(i_start_write) |-> !o_conversion_start_flag && !o_converting)
    else $error("start flag not cleared");
  conv_len_a: assert property (single_end_s |->
    conv_len == ratio * 12'h00d + 12'h001 || conv_len == ratio * 12'h019 + 12'h001)
    else $error("bad length");
  sel_lock_a: assert property ($rose(o_converting) |=>
    $stable({o_active_channel, o_active_reference})[*8])
    else $error("selection moved");
  sample_in_a: assert property (o_sample_hold |-> o_converting && $past(o_converting))
    else $error("sample outside conversion");
  irq_done_a: assert property (o_irq_request == (o_conversion_done_flag && i_done_int_enable))
    else $error("irq wrong");
  free_restart_a: assert property ($rose(o_conversion_done_flag) && i_auto_trigger_on
    && i_free_running && i_converter_on |-> restart_s)
    else $error("no free restart");
  off_idle_a: assert property (!i_converter_on ##1 !i_converter_on |->
    !o_converting && !o_sample_hold && !o_conversion_start_flag)
    else $error("active while off");
  done_valid_a: assert property ($rose(o_conversion_done_flag) |-> o_result_valid)
    else $error("no result word");
endmodule

bind adc_conversion_sequencer adc_seq_checker i_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_converter_on(i_converter_on),
  .i_start_write(i_start_write), .i_auto_trigger_on(i_auto_trigger_on),
  .i_free_running(i_free_running), .i_clock_divider_select(i_clock_divider_select),
  .i_done_int_enable(i_done_int_enable), .o_sample_hold(o_sample_hold),
  .o_converting(o_converting), .o_active_channel(o_active_channel),
  .o_active_reference(o_active_reference), .o_conversion_start_flag(o_conversion_start_flag),
  .o_conversion_done_flag(o_conversion_done_flag), .o_irq_request(o_irq_request),
  .o_result_valid(o_result_valid));
`default_nettype wire

// file: verif/sar_front_model.sv
// Analog front end model returning a value coded from the sampled selection
`timescale 1ns/1ps
`default_nettype none

module sar_front_model (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  input  wire logic                             i_sample_hold,
  input  wire logic [adc_seq_pkg::CHAN_W-1:0]   i_channel,
  input  wire logic                             i_reference,
  output logic      [adc_seq_pkg::RESULT_W-1:0] o_sar_value
);
  logic [4:0] held;
  logic       have;
  logic [9:0] noise;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held <= 5'h00;
      have <= 1'b0;
      noise <= 10'h2a5;
    end else begin
      noise <= ~noise;
      if (i_sample_hold) begin
        held <= {i_reference, i_channel};
        have <= 1'b1;
      end
    end
  end
  // Before any sample the value toggles, so an early read cannot match
  assign o_sar_value = have ? {held, ~held} : noise;
endmodule
`default_nettype wire

// file: verif/test_adc_conversion_sequencer.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module test_adc_conversion_sequencer;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        on = 1'b0, start = 1'b0, auto_on = 1'b0, free = 1'b0, clr = 1'b0;
  logic        ien = 1'b0, trig = 1'b0, slp = 1'b0, selw = 1'b0, rd_lo = 1'b0;
  logic        rd_hi = 1'b0, rdy = 1'b1;
  logic [2:0]  div = 3'h6;
  logic [4:0]  sel = 5'h00;
  logic [9:0]  sar;
  logic        sh, conv, act_ref, sflag, dflag, irq, valid;
  logic [3:0]  act_ch;
  logic [7:0]  lo, hi;
  adc_seq_pkg::result_word_t rdata;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          c0, n, rr;
  logic [31:0] rnd = 32'h61ce0dce;
  logic [9:0]  last_val = 10'h000;
  logic [4:0]  q [5];

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;

  adc_conversion_sequencer i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_converter_on(on), .i_start_write(start),
    .i_auto_trigger_on(auto_on), .i_free_running(free), .i_clock_divider_select(div),
    .i_done_clear(clr), .i_done_int_enable(ien), .i_trigger(trig), .i_sleep_halt(slp),
    .i_select_write(selw), .i_input_channel_field(sel[3:0]), .i_reference_select_bit(sel[4]),
    .i_read_low(rd_lo), .i_read_high(rd_hi), .i_sar_value(sar), .o_sample_hold(sh),
    .o_converting(conv), .o_active_channel(act_ch), .o_active_reference(act_ref),
    .o_conversion_start_flag(sflag), .o_conversion_done_flag(dflag), .o_irq_request(irq),
    .o_result_low_byte(lo), .o_result_high_byte(hi), .o_result_valid(valid),
    .i_result_ready(rdy), .o_result_data(rdata));

  sar_front_model i_front (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sample_hold(sh),
    .i_channel(act_ch), .i_reference(act_ref), .o_sar_value(sar));

  // ====
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [9:0] exp_val(input logic [4:0] s);
    return {s, ~s};
  endfunction
  function automatic int ratio(input logic [2:0] d);
    return (d == 3'h0) ? 2 : (1 << d);
  endfunction
  function automatic logic pick(input int w);
    case (w)
      0: return conv;
      1: return sh;
      default: return dflag;
    endcase
  endfunction
  task step(input int k);
    repeat (k) @(posedge i_clk);
    #5;
  endtask
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task wait_hi(input int w);
    int k;
    k = 0;
    while (pick(w) !== 1'b1) begin
      step(1);
      k++;
      if (k > 4000) begin
        fails++;
        $display("wrong value wait %0d expected 1 seen 0", w);
        give_verdict;
      end
    end
  endtask
  task set_sel(input logic [4:0] s);
    sel = s;
    selw = 1'b1;
    step(1);
    selw = 1'b0;
  endtask
  task clear_done;
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(1);
  endtask
  task run_single(input int sh_h, input int tot_h, input bit upd);
    logic [4:0] s_old;
    int cw;
    rr = ratio(div);
    s_old = sel;
    cw = cyc;
    start = 1'b1;
    step(1);
    start = 1'b0;
    wait_hi(0);
    c0 = cyc;
    check("start wait", 16'(cyc - cw <= rr + 2), 16'h0001);
    wait_hi(1);
    check("sample delay", 16'(cyc - c0), 16'(sh_h * rr / 2));
    rnd = lfsr(rnd);
    sel = rnd[4:0];
    selw = 1'b1;
    start = 1'b1;
    step(1);
    selw = 1'b0;
    start = 1'b0;
    step(1);
    check("active locked", 16'({act_ref, act_ch}), 16'(s_old));
    wait_hi(2);
    check("conv length", 16'(cyc - c0), 16'(tot_h * rr / 2 + 1));
    check("start flag", 16'(sflag), 16'h0000);
    if (upd) last_val = exp_val(s_old);
    check("result bytes", {hi, lo}, 16'(last_val));
    check("stream value", 16'(rdata.value), 16'(exp_val(s_old)));
    check("active updated", 16'({act_ref, act_ch}), 16'(sel));
    check("irq", 16'(irq), 16'(ien));
    clear_done;
  endtask
  task endt(input string name);
    $display("test %s finished", name);
  endtask

  // ====
  // Main sequence
  initial begin
    repeat (4) @(posedge i_clk);
    #5;
    i_rst_n = 1'b1;
    check("reset outputs", 16'({sflag, dflag, conv, valid, irq, sh}), 16'h0000);
    step(2);
    on = 1'b1; // ratio 64 gives 156 kHz
    set_sel(5'h13);
    run_single(27, 50, 1'b1);
    endt("first conversion");
    // All eight divider codes, ratios 2 to 128, each with a full normal conversion
    for (int d = 0; d < 8; d++) begin
      div = 3'(d);
      run_single(3, 26, 1'b1);
    end
    endt("divider ratios");
    div = 3'h6;
    rd_lo = 1'b1;
    step(1);
    rd_lo = 1'b0;
    run_single(3, 26, 1'b0);
    rd_hi = 1'b1;
    step(1);
    rd_hi = 1'b0;
    run_single(3, 26, 1'b1);
    endt("result lock");
    // Auto trigger, second edge mid-conversion
    auto_on = 1'b1;
    rr = 64;
    trig = 1'b1;
    c0 = cyc;
    wait_hi(1);
    n = cyc - c0;
    check("trigger sample", 16'(n >= 2 * rr + 2 && n <= 2 * rr + 6), 16'h0001);
    trig = 1'b0;
    step(3);
    trig = 1'b1;
    wait_hi(2);
    n = cyc - c0;
    check("trigger length", 16'(n >= 27 * rr / 2 && n <= 27 * rr / 2 + 8), 16'h0001);
    step(2 * rr);
    check("edge ignored", 16'(conv), 16'h0000);
    trig = 1'b0;
    clear_done;
    endt("auto trigger");
    // Free running into a stalled buffer
    free = 1'b1;
    rdy = 1'b0;
    set_sel(5'h0a);
    start = 1'b1;
    step(1);
    start = 1'b0;
    wait_hi(2);
    set_sel(5'h15);
    clear_done;
    check("free start flag", 16'(sflag), 16'h0001);
    step(3000);
    check("buffer held", 16'({valid, sflag}), 16'h0003);
    q = '{5'h0a, 5'h0a, 5'h15, 5'h15, 5'h15};
    n = 0;
    for (int k = 0; k < 4000 && n < 5; k++) begin
      rnd = lfsr(rnd);
      rdy = rnd[0];
      if (valid === 1'b1 && rdy) begin
        check("free word", 16'(rdata.value), 16'(exp_val(q[n])));
        n++;
      end
      step(1);
    end
    check("drained", 16'(n), 16'h0005);
    rdy = 1'b1;
    on = 1'b0;
    step(2);
    check("abort", 16'({conv, sflag}), 16'h0000);
    free = 1'b0;
    auto_on = 1'b0;
    endt("free running");
    // Sleep start, early wake
    on = 1'b1;
    ien = 1'b1;
    clear_done;
    set_sel(5'h07);
    slp = 1'b1;
    wait_hi(0);
    step(2);
    slp = 1'b0;
    wait_hi(2);
    check("sleep irq", 16'(irq), 16'h0001);
    check("sleep value", 16'(rdata.value), 16'(exp_val(5'h07)));
    endt("sleep start");
    give_verdict;
  end
endmodule
`default_nettype wire
